// ### rtl/egrx_status_regs.sv
// Purpose: e3 g832 receive overhead status and error count registers on apb
// Assumes: overhead bytes and error pulses come from the framer on pclk
// Notes:   pready always high; unmapped reads return zero, pslverr low
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module egrx_status_regs
    import egrx_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // frame overhead from framer
    input  wire logic        frame_strobe,
    input  wire logic [7:0]  ma_byte,
    input  wire logic [3:0]  ti_bits,
    input  wire logic [7:0]  nr_byte,
    input  wire logic [7:0]  gc_byte,
    // error events
    input  wire logic        framing_error,
    input  wire logic        parity_error,
    input  wire logic        remote_error,
    input  wire logic        perf_monitor_update,
    // interrupt
    output logic             irq
);
    logic [2:0]                 rx_payload_type;
    logic [3:0]                 timing_source_indication;
    logic [3:0]                 ti_stable;
    logic [2:0]                 ma_tail_stable;
    logic [7:0]                 rx_general_comm_byte;
    logic [7:0]                 rx_network_requirement_byte;
    logic [EGRX_CNT_W-1:0]      framing_error_count;
    logic [EGRX_CNT_W-1:0]      parity_error_count;
    logic [EGRX_CNT_W-1:0]      remote_error_count;
    logic                       pt_chg;
    logic                       ti_chg;
    logic                       tail_chg;
    logic                       nr_chg;
    logic                       gc_chg;
    logic                       ti_extract_en;
    logic                       next_ti_extract_en;
    logic [EGRX_INT_W-1:0]      int_status;
    logic [EGRX_INT_W-1:0]      next_int_status;
    logic [EGRX_INT_W-1:0]      int_mask;
    logic [EGRX_INT_W-1:0]      next_int_mask;
    logic [EGRX_INT_W-1:0]      int_events;
    logic [31:0]                next_prdata;
    logic                       wr_acc;
    logic                       rd_acc;
    logic                       wr_lane0;
    logic                       next_irq;

    // per-source error counters, indexed by the channel constants
    logic [EGRX_N_CNT-1:0]      err_evt;
    logic [EGRX_CNT_W-1:0]      err_cnt [EGRX_N_CNT];

    // address match, one flag per register
    logic                       hit_ma;
    logic                       hit_nrgc;
    logic                       hit_fec;
    logic                       hit_pec;
    logic                       hit_rec;
    logic                       hit_ctrl;
    logic                       hit_istat;
    logic                       hit_imask;

    // assembled read words
    logic [31:0]                ma_word;
    logic [31:0]                nrgc_word;
    logic [31:0]                fec_word;
    logic [31:0]                pec_word;
    logic [31:0]                rec_word;
    logic [31:0]                ctrl_word;
    logic [31:0]                istat_word;
    logic [31:0]                imask_word;
    logic [31:0]                rd_word;

    // MA bits 3..5 are ma_byte[5:3], bits 6..8 are ma_byte[2:0] (msb first)
    egrx_integrator #(.W(3)) u_pt (
        .pclk         (pclk),
        .presetn      (presetn),
        .frame_strobe (frame_strobe),
        .sample       (ma_byte[5:3]),
        .stable       (rx_payload_type),
        .changed      (pt_chg)
    );

    egrx_integrator #(.W(4)) u_ti (
        .pclk         (pclk),
        .presetn      (presetn),
        .frame_strobe (frame_strobe),
        .sample       (ti_bits),
        .stable       (ti_stable),
        .changed      (ti_chg)
    );

    egrx_integrator #(.W(3)) u_tail (
        .pclk         (pclk),
        .presetn      (presetn),
        .frame_strobe (frame_strobe),
        .sample       (ma_byte[2:0]),
        .stable       (ma_tail_stable),
        .changed      (tail_chg)
    );

    egrx_integrator #(.W(8)) u_nr (
        .pclk         (pclk),
        .presetn      (presetn),
        .frame_strobe (frame_strobe),
        .sample       (nr_byte),
        .stable       (rx_network_requirement_byte),
        .changed      (nr_chg)
    );

    egrx_integrator #(.W(8)) u_gc (
        .pclk         (pclk),
        .presetn      (presetn),
        .frame_strobe (frame_strobe),
        .sample       (gc_byte),
        .stable       (rx_general_comm_byte),
        .changed      (gc_chg)
    );

    // visible counts lag the events until the next update pulse
    assign err_evt[EGRX_CH_FE] = framing_error;
    assign err_evt[EGRX_CH_PE] = parity_error;
    assign err_evt[EGRX_CH_RE] = remote_error;

    generate
        for (genvar ch = 0; ch < EGRX_N_CNT; ch = ch + 1) begin : g_cnt
            egrx_err_counter u_cnt (
                .pclk                (pclk),
                .presetn             (presetn),
                .err_event           (err_evt[ch]),
                .perf_monitor_update (perf_monitor_update),
                .count               (err_cnt[ch]),
                .nonzero             ()
            );
        end
    endgenerate

    assign framing_error_count = err_cnt[EGRX_CH_FE];
    assign parity_error_count  = err_cnt[EGRX_CH_PE];
    assign remote_error_count  = err_cnt[EGRX_CH_RE];

    // both timing integrators keep running, so a mode change shows an
    // already integrated value at once
    always_comb begin
        if (ti_extract_en) begin
            timing_source_indication = ti_stable;
        end else begin
            timing_source_indication = {1'b0, ma_tail_stable};
        end
    end

    // no wait states: every register is a flop or a wire
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && !penable && !pwrite;
    assign wr_lane0 = wr_acc && pstrb[EGRX_WR_LANE];

    // 16-bit registers sit in the low half of the word, upper bits read zero
    assign ma_word    = {25'h0, rx_payload_type, timing_source_indication};
    assign nrgc_word  = {16'h0, rx_general_comm_byte,
                         rx_network_requirement_byte};
    assign fec_word   = {16'h0, framing_error_count};
    assign pec_word   = {16'h0, parity_error_count};
    assign rec_word   = {16'h0, remote_error_count};
    assign ctrl_word  = {31'h0, ti_extract_en};
    assign istat_word = {26'h0, int_status};
    assign imask_word = {26'h0, int_mask};

    // one address match shared by the read and write paths
    always_comb begin
        hit_ma    = 1'b0;
        hit_nrgc  = 1'b0;
        hit_fec   = 1'b0;
        hit_pec   = 1'b0;
        hit_rec   = 1'b0;
        hit_ctrl  = 1'b0;
        hit_istat = 1'b0;
        hit_imask = 1'b0;
        if (paddr == EGRX_MA_OFS) begin
            hit_ma = 1'b1;
        end else if (paddr == EGRX_NRGC_OFS) begin
            hit_nrgc = 1'b1;
        end else if (paddr == EGRX_FEC_OFS) begin
            hit_fec = 1'b1;
        end else if (paddr == EGRX_PEC_OFS) begin
            hit_pec = 1'b1;
        end else if (paddr == EGRX_REC_OFS) begin
            hit_rec = 1'b1;
        end else if (paddr == EGRX_CTRL_OFS) begin
            hit_ctrl = 1'b1;
        end else if (paddr == EGRX_ISTAT_OFS) begin
            hit_istat = 1'b1;
        end else if (paddr == EGRX_IMASK_OFS) begin
            hit_imask = 1'b1;
        end
    end

    // a timing change event follows whichever source is visible
    always_comb begin
        int_events                = '0;
        int_events[EGRX_I_PT]     = pt_chg;
        int_events[EGRX_I_TI]     = ti_extract_en ? ti_chg : tail_chg;
        int_events[EGRX_I_NR]     = nr_chg;
        int_events[EGRX_I_GC]     = gc_chg;
        int_events[EGRX_I_FE]     = framing_error;
        int_events[EGRX_I_PE]     = parity_error;
    end

    always_comb begin
        next_ti_extract_en = ti_extract_en;
        next_int_mask      = int_mask;
        next_int_status    = int_status;
        // only byte lane 0 carries writable bits
        if (wr_lane0) begin
            if (hit_ctrl) begin
                next_ti_extract_en = pwdata[EGRX_CTRL_TIX];
            end else if (hit_imask) begin
                next_int_mask = pwdata[EGRX_INT_W-1:0];
            end else if (hit_istat) begin
                next_int_status = int_status & ~pwdata[EGRX_INT_W-1:0];
            end
        end
        // set wins over a simultaneous clear
        next_int_status = next_int_status | int_events;
        next_irq        = |(next_int_status & next_int_mask);
    end

    // unmapped addresses read zero
    always_comb begin
        rd_word = 32'h0;
        if (hit_ma) begin
            rd_word = ma_word;
        end else if (hit_nrgc) begin
            rd_word = nrgc_word;
        end else if (hit_fec) begin
            rd_word = fec_word;
        end else if (hit_pec) begin
            rd_word = pec_word;
        end else if (hit_rec) begin
            rd_word = rec_word;
        end else if (hit_ctrl) begin
            rd_word = ctrl_word;
        end else if (hit_istat) begin
            rd_word = istat_word;
        end else if (hit_imask) begin
            rd_word = imask_word;
        end
    end

    // read data registered in setup so it is stable through the access phase
    always_comb begin
        next_prdata = prdata;
        if (rd_acc) begin
            next_prdata = rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ti_extract_en <= 1'b0;
            int_status    <= '0;
            int_mask      <= '0;
            prdata        <= 32'h0;
            irq           <= 1'b0;
        end else begin
            ti_extract_en <= next_ti_extract_en;
            int_status    <= next_int_status;
            int_mask      <= next_int_mask;
            prdata        <= next_prdata;
            irq           <= next_irq;
        end
    end
endmodule // egrx_status_regs

// ### include/egrx_pkg.sv
// Purpose: constants for the e3 g832 receive overhead status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   byte address of a register is four times its index
package egrx_pkg;
    // register indices; some are not multiples of four, so each index is scaled to a byte address
    localparam logic [11:0] EGRX_MA_IDX     = 12'h130;
    localparam logic [11:0] EGRX_NRGC_IDX   = 12'h132;
    localparam logic [11:0] EGRX_FEC_IDX    = 12'h134;
    localparam logic [11:0] EGRX_PEC_IDX    = 12'h136;
    localparam logic [11:0] EGRX_REC_IDX    = 12'h138;
    localparam logic [11:0] EGRX_CTRL_IDX   = 12'h140;
    localparam logic [11:0] EGRX_ISTAT_IDX  = 12'h144;
    localparam logic [11:0] EGRX_IMASK_IDX  = 12'h148;
    localparam int          EGRX_ADDR_SH    = 2;
    localparam logic [11:0] EGRX_MA_OFS     = EGRX_MA_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_NRGC_OFS   = EGRX_NRGC_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_FEC_OFS    = EGRX_FEC_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_PEC_OFS    = EGRX_PEC_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_REC_OFS    = EGRX_REC_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_CTRL_OFS   = EGRX_CTRL_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_ISTAT_OFS  = EGRX_ISTAT_IDX << EGRX_ADDR_SH;
    localparam logic [11:0] EGRX_IMASK_OFS  = EGRX_IMASK_IDX << EGRX_ADDR_SH;
    // control field and write lane
    localparam int          EGRX_CTRL_TIX   = 0;
    localparam int          EGRX_WR_LANE    = 0;
    // error counter channels
    localparam int          EGRX_N_CNT      = 3;
    localparam int          EGRX_CH_FE      = 0;
    localparam int          EGRX_CH_PE      = 1;
    localparam int          EGRX_CH_RE      = 2;
    localparam int          EGRX_CNT_W      = 16;
    localparam int          EGRX_INT_W      = 6;
    localparam int          EGRX_INTEG_FRM  = 3;
    localparam int          EGRX_INTEG_CW   = 2;
    localparam logic [15:0] EGRX_REG_RST    = 16'h0000;
    localparam logic [15:0] EGRX_CNT_MAX    = 16'hffff;
    // interrupt status bits
    localparam int          EGRX_I_PT       = 0;
    localparam int          EGRX_I_TI       = 1;
    localparam int          EGRX_I_NR       = 2;
    localparam int          EGRX_I_GC       = 3;
    localparam int          EGRX_I_FE       = 4;
    localparam int          EGRX_I_PE       = 5;
endpackage

// ### rtl/egrx_integrator.sv
// Purpose: persistence filter for one overhead field
// Assumes: frame_strobe pulses once per frame with a new sample
// Notes:   output changes only after EGRX_INTEG_FRM equal samples in a row
`timescale 1ns/10ps
module egrx_integrator
    import egrx_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // sample in
    input  wire logic         frame_strobe,
    input  wire logic [W-1:0] sample,
    // integrated out
    output logic      [W-1:0] stable,
    output logic              changed
);
    logic [W-1:0]              cand;
    logic [W-1:0]              next_cand;
    logic [EGRX_INTEG_CW-1:0]  run;
    logic [EGRX_INTEG_CW-1:0]  next_run;
    logic [W-1:0]              next_stable;
    logic                      next_changed;

    localparam logic [EGRX_INTEG_CW-1:0] RUN_DONE = EGRX_INTEG_CW'(EGRX_INTEG_FRM - 1);

    always_comb begin
        next_cand    = cand;
        next_run     = run;
        next_stable  = stable;
        next_changed = 1'b0;
        if (frame_strobe) begin
            if (sample != cand) begin
                next_cand = sample;
                next_run  = '0;
            end else if (run != RUN_DONE) begin
                next_run = run + 1'b1;
            end
            if (sample == cand && (run == RUN_DONE || run + 1'b1 == RUN_DONE)
                && sample != stable) begin
                next_stable  = sample;
                next_changed = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cand    <= '0;
            run     <= '0;
            stable  <= '0;
            changed <= 1'b0;
        end else begin
            cand    <= next_cand;
            run     <= next_run;
            stable  <= next_stable;
            changed <= next_changed;
        end
    end
endmodule // egrx_integrator

// ### rtl/egrx_err_counter.sv
// Purpose: error event counter with snapshot on performance update
// Assumes: event and update are single-cycle pulses on pclk
// Notes:   counter saturates; snapshot restarts accumulation
`timescale 1ns/10ps
module egrx_err_counter
    import egrx_pkg::*;
(
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // events
    input  wire logic                  err_event,
    input  wire logic                  perf_monitor_update,
    // visible count
    output logic      [EGRX_CNT_W-1:0] count,
    output logic                       nonzero
);
    logic [EGRX_CNT_W-1:0] acc;
    logic [EGRX_CNT_W-1:0] next_acc;
    logic [EGRX_CNT_W-1:0] next_count;

    always_comb begin
        next_acc   = acc;
        next_count = count;
        if (perf_monitor_update) begin
            next_count = (err_event && acc != EGRX_CNT_MAX) ? acc + 1'b1 : acc;
            next_acc   = EGRX_REG_RST;
        end else if (err_event && acc != EGRX_CNT_MAX) begin
            next_acc = acc + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc   <= EGRX_REG_RST;
            count <= EGRX_REG_RST;
        end else begin
            acc   <= next_acc;
            count <= next_count;
        end
    end

    assign nonzero = (count != EGRX_REG_RST);
endmodule // egrx_err_counter

// ### tb/egrx_status_regs_assertions.sv
// Purpose: port-level checks for egrx_status_regs
// Assumes: pready tied high, read data loaded at the setup edge
// Notes:   bound to every instance of the register block
`timescale 1ns/10ps
module egrx_status_regs_chk
    import egrx_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // events and interrupt
    input wire logic        perf_monitor_update,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rs;
    assign rs = psel && !penable && !pwrite;
    property p_ma;
        rs && paddr == EGRX_MA_OFS |=> prdata[31:7] == 25'h0;
    endproperty
    a_ma: assert property (p_ma) else $error("ma word has upper bits set");
    property p_nrgc;
        rs && paddr == EGRX_NRGC_OFS |=> prdata[31:16] == 16'h0;
    endproperty
    a_nrgc: assert property (p_nrgc) else $error("nr gc word too wide");
    property p_fec;
        rs && paddr == EGRX_FEC_OFS |=> prdata[31:16] == 16'h0;
    endproperty
    a_fec: assert property (p_fec) else $error("framing count too wide");
    property p_pec;
        rs && paddr == EGRX_PEC_OFS |=> prdata[31:16] == 16'h0;
    endproperty
    a_pec: assert property (p_pec) else $error("parity count too wide");
    property p_rec;
        rs && paddr == EGRX_REC_OFS |=> prdata[31:16] == 16'h0;
    endproperty
    a_rec: assert property (p_rec) else $error("remote count too wide");
    property p_hold;
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved outside setup");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase stalled");
    property p_noerr;
        psel && penable |-> !pslverr;
    endproperty
    a_noerr: assert property (p_noerr) else $error("slave error raised");
    c_irq: cover property ($rose(irq));
    c_pmu: cover property (perf_monitor_update);
    c_ma: cover property (rs && paddr == EGRX_MA_OFS);
endmodule // egrx_status_regs_chk

bind egrx_status_regs egrx_status_regs_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .perf_monitor_update(perf_monitor_update), .irq(irq));

// ### tb/egrx_frame_src.sv
// Purpose: model of the incoming g832 frame stream and error events
// Assumes: one overhead sample per frame_strobe pulse
// Notes:   bytes show the inverse between frames
`timescale 1ns/10ps
module egrx_frame_src (
    // clock
    input  wire logic       pclk,
    // frame overhead
    output logic            frame_strobe,
    output logic      [7:0] ma_byte,
    output logic      [3:0] ti_bits,
    output logic      [7:0] nr_byte,
    output logic      [7:0] gc_byte,
    // error events
    output logic            framing_error,
    output logic            parity_error,
    output logic            remote_error
);
    initial begin
        {frame_strobe, framing_error, parity_error, remote_error} = 4'h0;
        {ma_byte, ti_bits, nr_byte, gc_byte} = 28'h0;
    end
    task frame(input logic [7:0] m, input logic [3:0] t, input logic [7:0] n,
               input logic [7:0] g, input int gap);
        @(posedge pclk);
        frame_strobe <= 1'b1;
        {ma_byte, ti_bits, nr_byte, gc_byte} <= {m, t, n, g};
        @(posedge pclk);
        frame_strobe <= 1'b0;
        // stale bytes must never pass for a new sample
        {ma_byte, ti_bits, nr_byte, gc_byte} <= ~{m, t, n, g};
        repeat (gap) @(posedge pclk);
    endtask
    // events back to back, one per high cycle
    task errs(input logic [15:0] f, input logic [15:0] p, input logic [15:0] q);
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            {framing_error, parity_error, remote_error} <= {i < f, i < p, i < q};
        end
        @(posedge pclk);
        {framing_error, parity_error, remote_error} <= 3'h0;
    endtask
endmodule // egrx_frame_src

// ### tb/egrx_status_regs_tb.sv
// Purpose: self-checking bench for egrx_status_regs
// Assumes: lfsr stimulus seeded at 93
// Notes:   expectations come from bench stimulus values and ma_exp only
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s exp %h got %h", n, e, g); end end
module egrx_status_regs_tb;
    import egrx_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        frame_strobe, framing_error, parity_error, remote_error;
    logic        perf_monitor_update, en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [7:0]  ma_byte, nr_byte, gc_byte, lf, ma, nr, gc, x, pma;
    logic [3:0]  ti_bits, ti, pti;
    logic [15:0] nf, np, nq, pf;
    int          mismatches, n_tests, cyc;
    egrx_status_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_strobe(frame_strobe), .ma_byte(ma_byte),
        .ti_bits(ti_bits), .nr_byte(nr_byte), .gc_byte(gc_byte),
        .framing_error(framing_error), .parity_error(parity_error),
        .remote_error(remote_error), .perf_monitor_update(perf_monitor_update), .irq(irq));
    egrx_frame_src src (.pclk(pclk), .frame_strobe(frame_strobe), .ma_byte(ma_byte),
        .ti_bits(ti_bits), .nr_byte(nr_byte), .gc_byte(gc_byte),
        .framing_error(framing_error), .parity_error(parity_error),
        .remote_error(remote_error));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function logic [7:0] rnd();
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf;
    endfunction
    function logic [31:0] ma_exp(input logic [7:0] m, input logic [3:0] t, input logic e);
        return {25'h0, m[5:3], e ? t : {1'b0, m[2:0]}};
    endfunction
    task close_out();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        d = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rc(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, d)
    endtask
    task irq_is(input string n, input logic e);
        repeat (3) @(posedge pclk);
        #1;
        `CHK(n, e, irq)
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        {psel, penable, pwrite, perf_monitor_update, presetn} = 5'h0;
        {paddr, pwdata} = 44'h0;
        {lf, pma, pti, pf} = {8'h5d, 28'h0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc("unmapped", 12'h13c, 32'h0);
        rc("ma_rst", EGRX_MA_OFS, 32'h0);
        rc("nrgc_rst", EGRX_NRGC_OFS, 32'h0);
        for (int k = 0; k < 4; k++) begin
            en = k[0];
            xfer(1'b1, EGRX_CTRL_OFS, {31'h0, en});
            rc("ctrl", EGRX_CTRL_OFS, {31'h0, en});
            ma = rnd();
            nr = rnd();
            gc = rnd();
            x = rnd();
            ti = x[7:4];
            // one odd frame breaks the run of equal samples
            for (int j = 0; j < 6; j++) begin
                if (j == 2)
                    src.frame(~ma, ~ti, ~nr, ~gc, j);
                else
                    src.frame(ma, ti, nr, gc, j);
                if (j == 4)
                    rc("ma_hold", EGRX_MA_OFS, ma_exp(pma, pti, en));
            end
            rc("ma", EGRX_MA_OFS, ma_exp(ma, ti, en));
            rc("nrgc", EGRX_NRGC_OFS, {16'h0, gc, nr});
            pma = ma;
            pti = ti;
        end
        for (int k = 0; k < 2; k++) begin
            x = rnd();
            nf = {13'h0, x[2:0]} + 16'h1;
            np = {13'h0, x[5:3]} + 16'h1;
            nq = {14'h0, x[7:6]} + 16'h1;
            src.errs(nf, np, nq);
            xfer(1'b1, EGRX_FEC_OFS, 32'hffff);
            rc("fe_hold", EGRX_FEC_OFS, {16'h0, pf});
            @(posedge pclk);
            perf_monitor_update <= 1'b1;
            @(posedge pclk);
            perf_monitor_update <= 1'b0;
            rc("fe", EGRX_FEC_OFS, {16'h0, nf});
            rc("pe", EGRX_PEC_OFS, {16'h0, np});
            rc("rei", EGRX_REC_OFS, {16'h0, nq});
            pf = nf;
        end
        xfer(1'b1, EGRX_ISTAT_OFS, 32'h3f);
        xfer(1'b1, EGRX_IMASK_OFS, 32'h1 << EGRX_I_FE);
        rc("imask", EGRX_IMASK_OFS, 32'h1 << EGRX_I_FE);
        irq_is("irq_idle", 1'b0);
        src.errs(16'h1, 16'h0, 16'h0);
        irq_is("irq_set", 1'b1);
        rc("istat", EGRX_ISTAT_OFS, 32'h1 << EGRX_I_FE);
        xfer(1'b1, EGRX_ISTAT_OFS, 32'h1 << EGRX_I_FE);
        irq_is("irq_clr", 1'b0);
        src.errs(16'h0, 16'h1, 16'h0);
        irq_is("irq_masked", 1'b0);
        rc("istat_pe", EGRX_ISTAT_OFS, 32'h1 << EGRX_I_PE);
        close_out();
    end
endmodule // egrx_status_regs_tb
